// [design/hs_write_defs.vh]
// constants shared by the high-speed write slave and its helpers
`ifndef HS_WRITE_DEFS_VH
`define HS_WRITE_DEFS_VH
// register byte offsets on the AXI4-Lite slave, plus control reset value and enable bit
`define REG_CONTROL 4'h0
`define REG_STATUS 4'h4
`define REG_RX_WORD 4'h8
`define CONTROL_RESET 32'h0000_0001
`define CONTROL_ENABLE_BIT 0
// status field positions
`define STATUS_RX_VALID_BIT 0
`define STATUS_ADDRESSED_BIT 1
`define STATUS_STRETCH_BIT 2
`define STATUS_PD_MODE_LO 3
`define STATUS_PD_MODE_HI 4
`define STATUS_CODE_SEEN_BIT 5
// received-word layout
`define ENTRY_W 16
`define ENTRY_PD_BIT 15
`define RX_WORD_VALID_BIT 16
// serial protocol constants and AXI response codes
`define ADDR_FIXED 5'h13
`define HS_CODE_TOP 5'h01
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [design/pin_sync.v]
// three-stage synchroniser with agreement filter for outside pins
`default_nettype none
module pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
  // clock and reset
  input wire ref_clk,
  input wire rst_b,
  // raw pins and filtered levels
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] level
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;
  genvar i;

  // stage1 feeds stage2 only, so metastability never reaches logic
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a change counts only once the last two stages agree
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          level[i] <= INIT[i];
        end else if (stage2[i] == stage3[i]) begin
          level[i] <= stage3[i];
        end
      end
    end
  endgenerate
endmodule // pin_sync
`default_nettype wire

// [design/word_buffer.v]
// small valid/ready buffer holding received words until software reads them
`default_nettype none
module word_buffer #(
  parameter WIDTH = 16,
  parameter DEPTH = 2,
  parameter PTR_W = 1
) (
  // clock and reset
  input wire ref_clk,
  input wire rst_b,
  // filling side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // draining side
  output wire out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PTR_W-1:0] wr_ptr;
  reg [PTR_W-1:0] rd_ptr;
  reg [PTR_W:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != DEPTH[PTR_W:0]);
  assign out_valid = (count != {(PTR_W+1){1'b0}});
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // storage written on push; no reset needed for data
  always @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers wrap at DEPTH, count keeps full and empty honest
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= {PTR_W{1'b0}};
      rd_ptr <= {PTR_W{1'b0}};
      count <= {(PTR_W+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

  // head word registered; it reaches out_data one cycle after out_valid rises
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_data <= {WIDTH{1'b0}};
    end else begin
      out_data <= mem[rd_ptr];
    end
  end
endmodule // word_buffer
`default_nettype wire

// [design/hs_write_slave.v]
// two-wire serial slave receiver for high-speed writes, with AXI4-Lite access
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`include "hs_write_defs.vh"
`default_nettype none
// Behaviour
// - the master code byte is never acknowledged
// - after repeated start, a matching write address is acknowledged by pulling data low
// - the control byte after an acknowledged address is acknowledged
// - control byte bit 0 picks power-down bytes or conversion data
// - with select 0, high/low pairs repeat until stop or repeated start
// - with select 1, exactly two power-down bytes follow the control byte
// - first byte of a pair is the eight sample bits, msb first, acknowledged
// - second byte of a pair is don't-care but clocked in and accepted
// - first power-down byte holds the mode in its top two bits; both acknowledged
// - device is reached with a seven-bit address
module hs_write_slave #(
  parameter ADDR_W = 4
) (
  // clock and reset
  input wire ref_clk,
  input wire rst_b,
  // axi4-lite write channels
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read channels
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // serial clock pin, open drain
  input wire scl_i,
  output wire scl_o,
  output reg scl_oe,
  // serial data pin, open drain
  input wire sda_i,
  output wire sda_o,
  output reg sda_oe,
  // address straps
  input wire addr_strap_hi,
  input wire addr_strap_lo
);
  localparam ST_IDLE = 3'd0;
  localparam ST_RX = 3'd1;
  localparam ST_HOLD = 3'd2;
  localparam ST_ACK = 3'd3;
  localparam ST_SKIP = 3'd4;
  localparam K_ADDR = 3'd0;
  localparam K_CTRL = 3'd1;
  localparam K_HIGH = 3'd2;
  localparam K_LOW = 3'd3;
  localparam K_PD1 = 3'd4;
  localparam K_PD2 = 3'd5;
  localparam K_DONE = 3'd6;

  wire [3:0] pins_f;
  wire scl_f;
  wire sda_f;
  wire strap_hi_f;
  wire strap_lo_f;
  reg scl_q;
  reg sda_q;
  wire scl_rise;
  wire scl_fall;
  wire start_cond;
  wire stop_cond;
  reg [2:0] st;
  reg [2:0] kind;
  reg [2:0] next_kind_q;
  reg [3:0] bitcnt;
  reg [7:0] shreg;
  reg ack_q;
  reg push_q;
  reg [1:0] load_mode;
  reg [1:0] chan_sel;
  reg [7:0] high_byte;
  reg powerdown_mode_hi;
  reg powerdown_mode_lo;
  reg code_seen;
  reg dec_ack;
  reg dec_push;
  reg [2:0] dec_kind;
  reg [`ENTRY_W-1:0] dec_entry;
  reg [`ENTRY_W-1:0] entry_q;
  wire buf_in_ready;
  reg buf_full;
  reg [1:0] buf_count;
  wire buf_out_valid;
  wire [`ENTRY_W-1:0] buf_out_data;
  reg buf_pop;
  reg [31:0] control;
  wire enable;
  reg aw_held;
  reg w_held;
  reg [ADDR_W-1:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  // pins and straps pass the three-stage filter
  pin_sync #(.WIDTH(4), .INIT(4'hf)) u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .pin_in({addr_strap_lo, addr_strap_hi, sda_i, scl_i}),
    .level(pins_f)
  );
  assign scl_f = pins_f[0];
  assign sda_f = pins_f[1];
  assign strap_hi_f = pins_f[2];
  assign strap_lo_f = pins_f[3];

  // open drain: only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign enable = control[`CONTROL_ENABLE_BIT];

  // edge and bus-condition detection on filtered levels
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end
  assign scl_rise = scl_f & ~scl_q;
  assign scl_fall = ~scl_f & scl_q;
  assign start_cond = scl_f & scl_q & sda_q & ~sda_f;
  assign stop_cond = scl_f & scl_q & ~sda_q & sda_f;

  // per-byte decision: acknowledge, follow-on byte, and word to hand over
  always @* begin
    dec_ack = 1'b0;
    dec_push = 1'b0;
    dec_kind = K_DONE;
    dec_entry = {`ENTRY_W{1'b0}};
    case (kind)
      K_ADDR: begin
        // seven address bits then the write flag
        if (shreg[7:3] == `HS_CODE_TOP) begin
          dec_ack = 1'b0; // master code never acknowledged
        end else begin
          dec_ack = (shreg[7:3] == `ADDR_FIXED) && (shreg[2] == strap_hi_f) &&
                    (shreg[1] == strap_lo_f) && !shreg[0];
        end
        dec_kind = K_CTRL;
      end
      K_CTRL: begin
        dec_ack = 1'b1;
        dec_kind = shreg[0] ? K_PD1 : K_HIGH; // select bit steers what follows
      end
      K_HIGH: begin
        dec_ack = 1'b1;
        dec_kind = K_LOW;
      end
      K_LOW: begin
        dec_ack = 1'b1; // low byte taken though ignored
        dec_push = 1'b1;
        dec_kind = K_HIGH; // pairs repeat until stop or restart
        dec_entry = {1'b0, load_mode, chan_sel, 3'h0, high_byte};
      end
      K_PD1: begin
        dec_ack = 1'b1;
        dec_kind = K_PD2;
      end
      K_PD2: begin
        dec_ack = 1'b1;
        dec_push = 1'b1;
        dec_kind = K_DONE; // only two power-down bytes are expected
        dec_entry = {1'b1, load_mode, chan_sel, 3'h0, powerdown_mode_hi, powerdown_mode_lo, 6'h00};
      end
      default: begin
        dec_ack = 1'b0; // surplus bytes after power-down are refused
        dec_kind = K_DONE;
      end
    endcase
  end

  // serial receive state machine
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= ST_IDLE;
      kind <= K_ADDR;
      next_kind_q <= K_ADDR;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      ack_q <= 1'b0;
      push_q <= 1'b0;
      entry_q <= {`ENTRY_W{1'b0}};
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
      load_mode <= 2'h0;
      chan_sel <= 2'h0;
      high_byte <= 8'h00;
      powerdown_mode_hi <= 1'b0;
      powerdown_mode_lo <= 1'b0;
      code_seen <= 1'b0;
    end else begin
      push_q <= 1'b0;
      if (!enable) begin
        // disabled: let go of both wires and ignore the bus
        st <= ST_IDLE;
        sda_oe <= 1'b0;
        scl_oe <= 1'b0;
      end else if (start_cond) begin
        // start or repeated start always returns to addressing
        st <= ST_RX;
        kind <= K_ADDR;
        bitcnt <= 4'h0;
        sda_oe <= 1'b0;
        scl_oe <= 1'b0;
      end else if (stop_cond) begin
        st <= ST_IDLE;
        sda_oe <= 1'b0;
        scl_oe <= 1'b0;
      end else begin
        case (st)
          ST_RX: begin
            if (scl_rise && bitcnt != 4'h8) begin
              shreg <= {shreg[6:0], sda_f}; // msb first
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              ack_q <= dec_ack;
              next_kind_q <= dec_kind;
              entry_q <= dec_entry;
              if (kind == K_ADDR && shreg[7:3] == `HS_CODE_TOP) begin
                code_seen <= 1'b1;
              end
              if (kind == K_CTRL) begin
                load_mode <= shreg[5:4];
                chan_sel <= shreg[2:1];
              end
              if (kind == K_HIGH) begin
                high_byte <= shreg;
              end
              if (kind == K_PD1) begin
                powerdown_mode_hi <= shreg[7];
                powerdown_mode_lo <= shreg[6];
              end
              sda_oe <= dec_ack;
              if (dec_push && !buf_in_ready) begin
                // buffer full: stretch the clock rather than drop a word
                scl_oe <= 1'b1;
                st <= ST_HOLD;
              end else begin
                push_q <= dec_push;
                st <= ST_ACK;
              end
            end
          end
          ST_HOLD: begin
            if (buf_in_ready) begin
              push_q <= 1'b1;
              scl_oe <= 1'b0;
              st <= ST_ACK;
            end
          end
          ST_ACK: begin
            // release data after the ninth clock falls
            if (scl_fall) begin
              sda_oe <= 1'b0;
              bitcnt <= 4'h0;
              kind <= next_kind_q;
              st <= ack_q ? ST_RX : ST_SKIP;
            end
          end
          ST_SKIP: begin
            st <= ST_SKIP; // wait for the next start or stop
          end
          default: begin
            st <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // received words wait here for software
  word_buffer #(.WIDTH(`ENTRY_W), .DEPTH(2), .PTR_W(1)) u_buf (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .in_valid(push_q),
    .in_ready(),
    .in_data(entry_q),
    .out_valid(buf_out_valid),
    .out_ready(buf_pop),
    .out_data(buf_out_data)
  );
  // ready seen by the receiver is built from buf_full and the buffer's out_valid, not from its in_ready
  assign buf_in_ready = ~buf_out_valid | ~buf_full;
  // shadow count so the stall decision does not race a push in flight
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      buf_count <= 2'h0;
      buf_full <= 1'b0;
    end else begin
      buf_count <= buf_count + {1'b0, push_q} - {1'b0, buf_pop};
      buf_full <= (buf_count + {1'b0, push_q} - {1'b0, buf_pop}) == 2'h2 ||
                  ((buf_count + {1'b0, push_q} - {1'b0, buf_pop}) == 2'h1 && push_q);
    end
  end

  // axi write: address and data taken in either order
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= {ADDR_W{1'b0}};
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      control <= `CONTROL_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `RESP_OKAY;
        if (aw_addr == `REG_CONTROL) begin
          if (w_strb[0]) begin
            control[7:0] <= w_data[7:0] & 8'h01;
          end
        end else if (aw_addr != `REG_STATUS && aw_addr != `REG_RX_WORD) begin
          s_axi_bresp <= `RESP_SLVERR; // unmapped
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi read: reading the word register pops one word
  assign s_axi_arready = ~s_axi_rvalid;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
      buf_pop <= 1'b0;
    end else begin
      buf_pop <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        case (s_axi_araddr)
          `REG_CONTROL: begin
            s_axi_rdata <= control;
          end
          `REG_STATUS: begin
            s_axi_rdata[`STATUS_RX_VALID_BIT] <= buf_out_valid;
            s_axi_rdata[`STATUS_ADDRESSED_BIT] <= (st != ST_IDLE) && (st != ST_SKIP);
            s_axi_rdata[`STATUS_STRETCH_BIT] <= scl_oe;
            s_axi_rdata[`STATUS_PD_MODE_HI] <= powerdown_mode_hi;
            s_axi_rdata[`STATUS_PD_MODE_LO] <= powerdown_mode_lo;
            s_axi_rdata[`STATUS_CODE_SEEN_BIT] <= code_seen;
          end
          `REG_RX_WORD: begin
            s_axi_rdata[`RX_WORD_VALID_BIT] <= buf_out_valid;
            s_axi_rdata[`ENTRY_W-1:0] <= buf_out_valid ? buf_out_data : {`ENTRY_W{1'b0}};
            buf_pop <= buf_out_valid & ~buf_pop;
          end
          default: begin
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // hs_write_slave
`default_nettype wire

// [sim/hs_write_checker_assertions.sv]
// port assertions for the high-speed write slave
`include "hs_write_defs.vh"
`default_nettype none
module hs_write_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // register bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial pins and straps
  input wire logic scl_i,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_oe,
  input wire logic addr_strap_hi,
  input wire logic addr_strap_lo
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  logic scl_q, sda_q, first;
  logic [3:0] nbits;
  logic [7:0] shreg;
  // raw-pin byte tracker, so ack timing is judged without the slave's filter
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      first <= 1'b0;
      nbits <= 4'h0;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      if (scl_i && scl_q && sda_q && !sda_i) begin
        nbits <= 4'h0;
        first <= 1'b1;
      end else if (scl_i && !scl_q) begin
        nbits <= (nbits == 4'h9) ? 4'h1 : nbits + 4'h1;
        if (nbits != 4'h8) shreg <= {shreg[6:0], sda_i};
        if (nbits == 4'h9) first <= 1'b0;
      end
    end
  end
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[2:3] s_axi_bvalid) else $error("write response late");
  a_b_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not cleared");
  a_no_new_write: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read data late");
  a_r_clear: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read data not cleared");
  a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_i)
    else $error("data pulled while clock high");
  a_ack_release_low: assert property ($fell(sda_oe) |-> !scl_i)
    else $error("data released while clock high");
  a_stretch_low: assert property ($rose(scl_oe) |-> !scl_i)
    else $error("stretch began with clock high");
  // scl_q skips the edge where the next byte's first rise still reads nbits as 9
  a_first_byte_ack: assert property (first && nbits == 4'h9 && scl_i && scl_q |->
    sda_oe == (shreg == {`ADDR_FIXED, addr_strap_hi, addr_strap_lo, 1'b0}))
    else $error("first byte acknowledge wrong");
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);
  c_stretch: cover property ($rose(scl_oe));
  c_ack: cover property ($rose(sda_oe));
endmodule // hs_write_checker
bind hs_write_slave hs_write_checker chk_u (.ref_clk(ref_clk), .rst_b(rst_b),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .scl_i(scl_i), .scl_oe(scl_oe),
  .sda_i(sda_i), .sda_oe(sda_oe), .addr_strap_hi(addr_strap_hi), .addr_strap_lo(addr_strap_lo));
`default_nettype wire

// [sim/i2c_master_model.sv]
// serial bus master model issuing write sequences
`default_nettype none
module i2c_master_model (
  // line levels seen
  input wire logic scl_line,
  input wire logic sda_line,
  // drives, 1 = released to pull-up
  output var logic scl_rel,
  output var logic sda_rel
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
  end
  // release clock and wait out any stretch by the slave
  task automatic clk_hi();
    scl_rel = 1'b1;
    while (!scl_line) #25;
  endtask
  // start or repeated start; long wait lets a held ack drop first
  task automatic start();
    sda_rel = 1'b1;
    #160 clk_hi();
    #100 sda_rel = 1'b0;
    #100 scl_rel = 1'b0;
  endtask
  // one bit in 200 ns; long low phase so a filtered ack release lands before the rise
  task automatic put_bit(input logic b, output logic seen);
    #10 sda_rel = b;
    #140 clk_hi();
    #50 seen = sda_line;
    scl_rel = 1'b0;
  endtask
  // byte msb first, then released ninth bit
  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(v[i], s);
    put_bit(1'b1, s);
    ack = !s;
  endtask
  task automatic stop();
    #10 sda_rel = 1'b0;
    #140 clk_hi();
    #100 sda_rel = 1'b1;
    #100;
  endtask
endmodule // i2c_master_model
`default_nettype wire

// [sim/hs_write_slave_tb.sv]
// testbench for the high-speed write slave
`include "hs_write_defs.vh"
`default_nettype none
module hs_write_slave_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] ADDR = 8'h9C;
  logic ref_clk, rst_b, strap_hi, strap_lo, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata;
  wire awready, wready, bvalid, arready, rvalid, scl_o, sda_o, scl_oe, sda_oe, scl_rel, sda_rel;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  // open-drain lines with pull-ups
  wire scl_line = scl_rel & (scl_oe ? scl_o : 1'b1);
  wire sda_line = sda_rel & (sda_oe ? sda_o : 1'b1);
  int error_cnt = 0;
  int total_checks = 0;
  hs_write_slave dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .scl_i(scl_line), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .addr_strap_hi(strap_hi),
    .addr_strap_lo(strap_lo));
  i2c_master_model master_u (.scl_line(scl_line), .sda_line(sda_line), .scl_rel(scl_rel), .sda_rel(sda_rel));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    do @(posedge ref_clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // masked read compare with okay response
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m, input string what);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check(what, exp, d & m);
    check("read resp", {30'h0, `RESP_OKAY}, {30'h0, r});
  endtask
  task automatic put(input logic [7:0] v, input logic ack, input string what);
    logic seen;
    master_u.send_byte(v, seen);
    check(what, {31'h0, ack}, {31'h0, seen});
  endtask
  function automatic logic [31:0] rx_word(input logic pd, input logic [1:0] ld, ch, input logic [7:0] s);
    return {15'h0, 1'b1, pd, ld, ch, 3'h0, s};
  endfunction
  // master code, repeated start, own address
  task automatic hs_open();
    master_u.start();
    put(8'h0F, 1'b0, "code nack");
    master_u.start();
    put(ADDR, 1'b1, "addr ack");
  endtask
  task automatic scen_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd(`REG_CONTROL, `CONTROL_RESET, 32'hFFFF_FFFF, "control reset");
    axi_read(4'hC, d, r);
    check("unmapped read", {30'h0, `RESP_SLVERR}, {30'h0, r});
    axi_write(4'hC, 32'h0000_0001, r);
    check("unmapped write", {30'h0, `RESP_SLVERR}, {30'h0, r});
    axi_write(`REG_CONTROL, 32'hFFFF_FFFE, r);
    check("control off resp", {30'h0, `RESP_OKAY}, {30'h0, r});
    rd(`REG_CONTROL, 32'h0000_0000, 32'hFFFF_FFFF, "control off");
    axi_write(`REG_CONTROL, 32'h0000_0001, r);
    check("control write", {30'h0, `RESP_OKAY}, {30'h0, r});
  endtask
  // three pairs into a two-word buffer: third low byte must stall
  task automatic scen_data();
    hs_open();
    put(8'h34, 1'b1, "ctrl ack");
    put(8'hA5, 1'b1, "hi ack");
    put(8'hFF, 1'b1, "lo ack");
    put(8'h3C, 1'b1, "hi2 ack");
    put(8'h00, 1'b1, "lo2 ack");
    put(8'h81, 1'b1, "hi3 ack");
    fork
      put(8'h5A, 1'b1, "lo3 ack");
      begin
        for (int n = 0; n < 800 && scl_oe !== 1'b1; n++) @(posedge ref_clk);
        check("stretch", 32'h1, {31'h0, scl_oe});
        rd(`REG_STATUS, 32'h0000_0007, 32'h0000_0007, "status stalled");
        rd(`REG_RX_WORD, rx_word(1'b0, 2'h3, 2'h2, 8'hA5), 32'hFFFF_FFFF, "word 1");
      end
    join
    master_u.stop();
    rd(`REG_RX_WORD, rx_word(1'b0, 2'h3, 2'h2, 8'h3C), 32'hFFFF_FFFF, "word 2");
    rd(`REG_RX_WORD, rx_word(1'b0, 2'h3, 2'h2, 8'h81), 32'hFFFF_FFFF, "word 3");
    rd(`REG_RX_WORD, 32'h0, 32'h0001_0000, "empty");
  endtask
  // power-down pair, extra byte refused, then readdress after repeated start
  task automatic scen_pd();
    hs_open();
    put(8'h27, 1'b1, "pd ctrl ack");
    put(8'h40, 1'b1, "pd first ack");
    put(8'hC3, 1'b1, "pd second ack");
    put(8'h00, 1'b0, "pd extra nack");
    master_u.start();
    put(ADDR, 1'b1, "readdress ack");
    master_u.stop();
    rd(`REG_RX_WORD, rx_word(1'b1, 2'h2, 2'h3, 8'h40), 32'hFFFF_FFFF, "pd word");
    rd(`REG_STATUS, 32'h0000_0028, 32'h0000_0038, "pd mode");
  endtask
  task automatic scen_refuse();
    master_u.start();
    put(8'h9E, 1'b0, "strap lo nack");
    master_u.start();
    put(8'h98, 1'b0, "strap hi nack");
    master_u.start();
    put(8'h9D, 1'b0, "read nack");
    master_u.stop();
    rd(`REG_RX_WORD, 32'h0, 32'h0001_0000, "no word");
  endtask
  initial begin
    rst_b <= 1'b0;
    strap_hi <= 1'b1;
    strap_lo <= 1'b0;
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b0;
    arvalid <= 1'b0;
    rready <= 1'b0;
    awaddr <= 4'h0;
    araddr <= 4'h0;
    wdata <= 32'h0000_0000;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (10) @(posedge ref_clk);
    scen_regs();
    scen_data();
    scen_pd();
    scen_refuse();
    complete_run();
  end
  // hang guard, several times the expected run
  initial begin
    #400_000;
    error_cnt++;
    $display("[FAIL] watchdog expected finish seen hang");
    complete_run();
  end
endmodule // hs_write_slave_tb
`default_nettype wire
